// >>> rtl/flash_status_regs.vh
// Opcodes, status bit positions and reset values for the status and
// write gating block. Definitions only; included by the block's module.
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// Status register bit positions
`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_BP_LSB 2
`define ST_BP_MSB 5
`define ST_QUAD_BIT 6
`define ST_WR_DIS_BIT 7
`define ST_RESET 8'h00

// Register access, latch control, reset and suspend
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_FUNCTION 8'h48
`define OP_READ_EXT_PARAMS 8'h81
`define OP_RESET_ENABLE 8'h66
`define OP_RESET_DEVICE 8'h99
`define OP_SUSPEND 8'h75

// Volatile register writes that run without the latch
`define OP_SET_READ_PARAMS_ALT 8'hc0
`define OP_WRITE_BANK_ALT 8'h17

// Chip erase codes
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60

// Pin synchroniser depth and frame counter width
`define SYNC_STAGES 3
`define FRAME_CNT_W 5
`endif

// >>> rtl/flash_status_write_gating.v
// Status register, busy tracking and write-enable gating of a serial flash.
// Assumes a mode 0 single-line serial host on the pins, sampled by
// core_clk_i; the array engines finish busy operations with op_done_i.
`timescale 1ns/10ps
`include "flash_status_regs.vh"

module flash_status_write_gating (
  input wire core_clk_i,
  input wire reset_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  output reg so_o,
  output wire so_oe_o,
  input wire io2_i,
  output wire io2_o,
  output wire io2_oe_o,
  input wire io3_i,
  output wire io3_o,
  output wire io3_oe_o,
  input wire [5:0] nv_bits_i,
  output reg nv_wr_o,
  output reg [5:0] nv_data_o,
  input wire op_done_i,
  output reg cmd_valid_o,
  output reg [7:0] cmd_code_o,
  output wire [7:0] status_o,
  output wire quad_enable_o,
  output wire hold_n_o,
  output reg ready_o
);

  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam NPINS = 4;
  localparam [NPINS-1:0] PIN_IDLE = 4'hc;

  // Three-flop synchronisers; a change counts when stages 2 and 3 agree
  wire [NPINS-1:0] pin_raw;
  reg [NPINS-1:0] sync1_q;
  reg [NPINS-1:0] sync2_q;
  reg [NPINS-1:0] sync3_q;
  reg [NPINS-1:0] pin_q;
  reg [NPINS-1:0] pin_prev_q;
  assign pin_raw = {io3_i, io2_i, si_i, sclk_i};

  wire [NPINS-1:0] pin_d;
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1)
    begin : g_sync
      assign pin_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : pin_q[g];
    end
  endgenerate

  // Protect and hold pins idle high; resetting their copies high avoids a
  // false protect or hold in the cycles after reset
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      sync3_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
      pin_prev_q <= PIN_IDLE;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  // Chip select idles high, so it gets its own synchroniser with set reset
  reg cs1_q;
  reg cs2_q;
  reg cs3_q;
  reg cs_q;
  reg cs_prev_q;
  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      cs3_q <= 1'b1;
      cs_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      cs1_q <= cs_n_i;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      if (cs2_q == cs3_q)
        cs_q <= cs3_q;
      cs_prev_q <= cs_q;
    end
  end

  wire sclk_rise = pin_q[0] & ~pin_prev_q[0];
  wire sclk_fall = ~pin_q[0] & pin_prev_q[0];
  wire si_bit = pin_q[1];
  wire cs_rise = cs_q & ~cs_prev_q;

  // Status bits
  reg state_q;
  reg busy_q;
  reg wr_latch_q;
  reg [3:0] bp_q;
  reg quad_en_q;
  reg sr_protect_q;
  assign status_o = {sr_protect_q, quad_en_q, bp_q, wr_latch_q, busy_q};
  assign quad_enable_o = quad_en_q;

  // With quad enabled both pins are data lines; the quad data path lives
  // elsewhere, so here they are never driven and lose their control role
  assign io2_o = 1'b0;
  assign io2_oe_o = 1'b0;
  assign io3_o = 1'b0;
  assign io3_oe_o = 1'b0;
  wire wp_n = quad_en_q | pin_q[2];
  assign hold_n_o = quad_en_q | pin_q[3];

  // Instruction classes
  function gated;
    input [7:0] op;
    begin
      case (op)
        8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e: gated = 1'b1;
        8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc,
        8'hc7, 8'h60: gated = 1'b1;
        8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h15,
        8'h18, 8'hc5: gated = 1'b1;
        8'hfb, 8'he1, 8'h64, 8'h62, 8'h91, 8'h7e, 8'h98: gated = 1'b1;
        8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'he8: gated = 1'b1;
        default: gated = 1'b0;
      endcase
    end
  endfunction

  // Gated writes that are purely volatile finish at once and leave busy clear
  function starts_busy;
    input [7:0] op;
    begin
      case (op)
        8'h63, 8'h83, 8'hc5, 8'hfb, 8'he1, 8'h91: starts_busy = 1'b0;
        default: starts_busy = gated(op);
      endcase
    end
  endfunction

  function allowed_busy;
    input [7:0] op;
    begin
      case (op)
        `OP_READ_STATUS, `OP_READ_FUNCTION, `OP_READ_EXT_PARAMS,
        `OP_RESET_ENABLE, `OP_RESET_DEVICE, `OP_SUSPEND: allowed_busy = 1'b1;
        default: allowed_busy = 1'b0;
      endcase
    end
  endfunction

  // Frame capture
  reg [`FRAME_CNT_W-1:0] bit_cnt_q;
  reg [7:0] shift_in_q;
  reg [7:0] opcode_q;
  reg [7:0] data_q;
  wire [7:0] in_byte = {shift_in_q[6:0], si_bit};
  wire have_op = bit_cnt_q >= 5'd8;
  wire have_data = bit_cnt_q >= 5'd16;

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      bit_cnt_q <= 5'h00;
      shift_in_q <= 8'h00;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
    end
    else if (cs_q)
      bit_cnt_q <= 5'h00;
    else if (sclk_rise)
    begin
      shift_in_q <= in_byte;
      if (bit_cnt_q != 5'h1f)
        bit_cnt_q <= bit_cnt_q + 5'd1;
      if (bit_cnt_q == 5'd7)
        opcode_q <= in_byte;
      if (bit_cnt_q == 5'd15)
        data_q <= in_byte;
    end
  end

  // Status read-out: the byte is reloaded every eight bits, so the host
  // sees a live busy flag while polling and the read repeats until select
  reg [2:0] out_cnt_q;
  reg [6:0] shift_out_q;
  reg out_en_q;
  wire reading = ~cs_q & have_op & (opcode_q == `OP_READ_STATUS);
  assign so_oe_o = out_en_q & ~cs_q;

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      out_cnt_q <= 3'h0;
      shift_out_q <= 7'h00;
      out_en_q <= 1'b0;
      so_o <= 1'b0;
    end
    else if (cs_q)
    begin
      out_cnt_q <= 3'h0;
      out_en_q <= 1'b0;
    end
    else if (reading & sclk_fall)
    begin
      out_en_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'd1;
      if (out_cnt_q == 3'd0)
      begin
        so_o <= status_o[7];
        shift_out_q <= status_o[6:0];
      end
      else
      begin
        so_o <= shift_out_q[6];
        shift_out_q <= {shift_out_q[5:0], 1'b0};
      end
    end
  end

  // Instruction execution at the end of the frame
  wire exec = cs_rise & have_op & (state_q == ST_RUN);
  wire accept = exec & (~busy_q | allowed_busy(opcode_q));
  wire sr_locked = sr_protect_q & ~wp_n;
  wire bp_clear = (bp_q == 4'h0);
  wire is_chip_erase = (opcode_q == `OP_CHIP_ERASE_A) | (opcode_q == `OP_CHIP_ERASE_B);

  always @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_LOAD;
      busy_q <= 1'b0;
      wr_latch_q <= 1'b0;
      bp_q <= 4'h0;
      quad_en_q <= 1'b0;
      sr_protect_q <= 1'b0;
      ready_o <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_data_o <= 6'h00;
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
    end
    else
    begin
      nv_wr_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      case (state_q)
        ST_LOAD:
        begin
          {sr_protect_q, quad_en_q, bp_q} <= nv_bits_i;
          ready_o <= 1'b1;
          state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (busy_q & op_done_i)
          begin
            busy_q <= 1'b0;
            wr_latch_q <= 1'b0;
          end
          if (accept)
          begin
            if (opcode_q == `OP_WRITE_ENABLE)
              wr_latch_q <= 1'b1;
            else if (opcode_q == `OP_WRITE_DISABLE)
              wr_latch_q <= 1'b0;
            else if (opcode_q == `OP_WRITE_STATUS)
            begin
              // Latch itself is left alone here
              if (wr_latch_q & have_data & ~sr_locked)
              begin
                {sr_protect_q, quad_en_q, bp_q} <= data_q[7:2];
                nv_data_o <= data_q[7:2];
                nv_wr_o <= 1'b1;
                busy_q <= 1'b1;
              end
            end
            else if (gated(opcode_q))
            begin
              // Discarded requests leave busy and outputs untouched
              if (wr_latch_q & ~(is_chip_erase & ~bp_clear))
              begin
                cmd_valid_o <= 1'b1;
                cmd_code_o <= opcode_q;
                busy_q <= starts_busy(opcode_q);
              end
            end
            else if (opcode_q != `OP_READ_STATUS)
            begin
              cmd_valid_o <= 1'b1;
              cmd_code_o <= opcode_q;
            end
          end
        end
        default:
          state_q <= ST_LOAD;
      endcase
    end
  end

endmodule

// >>> test/flash_status_monitor.sv
// Checker bound to the top ports of the status and write gating block.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/10ps
module flash_status_monitor (
  input wire core_clk_i,
  input wire reset_i,
  input wire op_done_i,
  input wire [7:0] status_o,
  input wire cmd_valid_o,
  input wire [7:0] cmd_code_o,
  input wire nv_wr_o,
  input wire [5:0] nv_data_o,
  input wire quad_enable_o,
  input wire hold_n_o,
  input wire io2_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_busy_holds: assert property (status_o[0] && !op_done_i |=> status_o[0])
    else $error("busy dropped early");
  a_done_clears_busy: assert property (op_done_i && status_o[0] |=> !status_o[0])
    else $error("busy not cleared");
  a_done_clears_latch: assert property (op_done_i && status_o[0] |=> !status_o[1])
    else $error("latch not cleared");
  a_gated_latch: assert property (cmd_valid_o && cmd_code_o inside {8'h02, 8'h20, 8'he8}
    |-> $past(status_o[1])) else $error("gated op without latch");
  a_erase_bp_zero: assert property (cmd_valid_o && cmd_code_o inside {8'hc7, 8'h60}
    |-> $past(status_o[5:2]) == 4'h0) else $error("chip erase while protected");
  a_busy_filter: assert property (cmd_valid_o && $past(status_o[0])
    |-> cmd_code_o inside {8'h05, 8'h48, 8'h81, 8'h66, 8'h99, 8'h75})
    else $error("op accepted while busy");
  a_nv_copy: assert property (nv_wr_o |-> ##[0:1] status_o[7:2] == nv_data_o)
    else $error("copies differ");
  a_latch_kept: assert property (nv_wr_o |=> status_o[1:0] == 2'b11)
    else $error("status write lost latch or busy");
  a_quad_pins: assert property (quad_enable_o == status_o[6] && !io2_oe_o
    && (!quad_enable_o || hold_n_o)) else $error("quad pin use wrong");
endmodule

bind flash_status_write_gating flash_status_monitor mon (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .op_done_i(op_done_i),
  .status_o(status_o),
  .cmd_valid_o(cmd_valid_o),
  .cmd_code_o(cmd_code_o),
  .nv_wr_o(nv_wr_o),
  .nv_data_o(nv_data_o),
  .quad_enable_o(quad_enable_o),
  .hold_n_o(hold_n_o),
  .io2_oe_o(io2_oe_o)
);

// >>> test/spi_host_model.sv
// Host serial controller model, mode 0, one instruction per select frame.
// Assumes the core clock as time base; sclk runs at 160 ns only in frames.
`timescale 1ns/10ps
module spi_host_model (
  input wire clk_i,
  input wire so_i,
  output reg sclk_o,
  output reg cs_n_o,
  output reg si_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Sends d[n-1:0] MSB first; rd keeps the last byte seen on so_i
  task automatic frame(input [23:0] d, input int n, output [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int k = n - 1; k >= 0; k--)
    begin
      @(posedge clk_i) si_o <= d[k];
      repeat (3) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      // Late in the high phase: the output trails the pin by several clocks
      @(negedge clk_i) rd = {rd[6:0], so_i};
      @(posedge clk_i) sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // A released line must not keep showing the last bit
    si_o <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// >>> test/flash_status_write_gating_tb_top.sv
// Self-checking bench for the status and write gating block.
// Assumes op_done_i pulses from the bench stand in for the array engines.
`timescale 1ns/10ps
module flash_status_write_gating_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fin = 1'b0;
  logic wp_n = 1'b1;
  logic hold_pin_n = 1'b1;
  logic [5:0] nv = 6'h00;
  logic [7:0] n_cmd = 8'h00;
  logic [7:0] n_nv = 8'h00;
  logic [7:0] r;
  logic [7:0] b;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  wire sck, cs_n, si, so, cv, nvw, rdy, qen, hold_n;
  wire [7:0] st;
  wire [7:0] code;
  wire [5:0] nvd;
  // Busy-starting codes first, latch-only volatile writes last
  logic [7:0] g [0:35] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21,
    8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15,
    8'h18, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h7e, 8'h98, 8'he8,
    8'h63, 8'h83, 8'hc5, 8'hfb, 8'he1, 8'h91};
  initial
  begin
    forever #10 clk = ~clk;
  end
  flash_status_write_gating dut (.core_clk_i(clk), .reset_i(rst), .sclk_i(sck), .cs_n_i(cs_n),
    .si_i(si), .so_o(so), .so_oe_o(), .io2_i(wp_n), .io2_o(), .io2_oe_o(), .io3_i(hold_pin_n),
    .io3_o(), .io3_oe_o(), .nv_bits_i(nv), .nv_wr_o(nvw), .nv_data_o(nvd), .op_done_i(fin),
    .cmd_valid_o(cv), .cmd_code_o(code), .status_o(st), .quad_enable_o(qen),
    .hold_n_o(hold_n), .ready_o(rdy));
  spi_host_model host (.clk_i(clk), .so_i(so), .sclk_o(sck), .cs_n_o(cs_n), .si_o(si));
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cv === 1'b1) n_cmd <= n_cmd + 8'h01;
    if (nvw === 1'b1) n_nv <= n_nv + 8'h01;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  task automatic check(input [7:0] seen, input [7:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input [7:0] c);
    host.frame({16'h0000, c}, 8, r);
  endtask
  task automatic wr_status(input [7:0] v);
    host.frame({8'h00, 8'h01, v}, 16, r);
  endtask
  task automatic rdst(input [7:0] e);
    // Three bytes long, so the byte judged is the repeated one
    host.frame(24'h050000, 24, r);
    check(r, e);
  endtask
  task automatic done;
    @(posedge clk) fin <= 1'b1;
    @(posedge clk) fin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset;
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 20 && rdy !== 1'b1; k++) @(posedge clk);
    repeat (8) @(posedge clk);
    check(st, {nv, 2'b00});
  endtask
  task automatic t_latch;
    rdst(8'h00);
    op(8'h06);
    check(st, 8'h02);
    rdst(8'h02);
    op(8'h04);
    check(st, 8'h00);
  endtask
  task automatic t_refuse;
    for (int k = 0; k < 36; k++)
    begin
      b = n_cmd;
      op(g[k]);
      check(n_cmd, b);
      check(st, 8'h00);
    end
    b = n_nv;
    wr_status(8'hfc);
    check(n_nv, b);
    check(st, 8'h00);
  endtask
  task automatic t_busy_ops;
    for (int k = 0; k < 30; k++)
    begin
      op(8'h06);
      b = n_cmd;
      op(g[k]);
      check(n_cmd, b + 8'h01);
      check(code, g[k]);
      rdst(8'h03);
      op(8'h04);
      check(st, 8'h03);
      done;
      check(st, 8'h00);
    end
  endtask
  task automatic t_ungated;
    b = n_cmd;
    op(8'hc0);
    op(8'h17);
    check(n_cmd, b + 8'h02);
    check(st, 8'h00);
    // Volatile gated writes run with the latch and leave busy clear
    for (int k = 30; k < 36; k++)
    begin
      op(8'h06);
      b = n_cmd;
      op(g[k]);
      check(n_cmd, b + 8'h01);
      check(st, 8'h02);
      op(8'h04);
    end
  endtask
  task automatic t_status_write;
    op(8'h06);
    b = n_nv;
    wr_status(8'h3f);
    check(n_nv, b + 8'h01);
    check({2'b00, nvd}, 8'h0f);
    check(st, 8'h3f);
    done;
    check(st, 8'h3c);
    op(8'h06);
    b = n_cmd;
    op(8'hc7);
    check(n_cmd, b);
    rdst(8'h3e);
  endtask
  task automatic t_protect;
    wr_status(8'h80);
    done;
    check(st, 8'h80);
    @(posedge clk) hold_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    check({7'h00, hold_n}, 8'h00);
    hold_pin_n <= 1'b1;
    @(posedge clk) wp_n <= 1'b0;
    op(8'h06);
    wr_status(8'h00);
    check(st, 8'h82);
    @(posedge clk) wp_n <= 1'b1;
    wr_status(8'h00);
    done;
    check(st, 8'h00);
  endtask
  task automatic t_nv_load;
    @(posedge clk) nv <= 6'h1f;
    hold_pin_n <= 1'b0;
    t_reset;
    check({7'h00, qen}, 8'h01);
    check({7'h00, hold_n}, 8'h01);
  endtask
  task automatic final_report;
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    t_reset;
    t_latch;
    t_refuse;
    t_busy_ops;
    t_ungated;
    t_status_write;
    t_protect;
    t_nv_load;
    final_report;
  end
endmodule
